// ---- logic/dbg_cmd_pkg.sv ----
// shared constants and types of the debug command decoder
package dbg_cmd_pkg;
  // command codes
  localparam logic [7:0] CMD_RD_STAT = 8'he4;
  localparam logic [7:0] CMD_WR_CTRL = 8'hc4;
  localparam logic [7:0] CMD_TGT_RST = 8'h18;
  localparam logic [7:0] CMD_HALT = 8'h90;
  localparam logic [7:0] CMD_RD_BYTE = 8'he0;
  localparam logic [7:0] CMD_RD_BYTE_ST = 8'he1;
  localparam logic [7:0] CMD_WR_BYTE = 8'hc0;
  localparam logic [7:0] CMD_WR_BYTE_ST = 8'hc1;
  localparam logic [7:0] CMD_BP_RD = 8'he2;
  localparam logic [7:0] CMD_BP_WR = 8'hc2;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_BLK_RD = 8'h80;
  localparam logic [7:0] CMD_BLK_WR = 8'h88;
  localparam logic [7:0] CMD_FPC_RD = 8'h6b;
  localparam logic [7:0] CMD_FPC_WR = 8'h4b;
  localparam logic [7:0] CMD_SPC_RD = 8'h6f;
  localparam logic [7:0] CMD_SPC_WR = 8'h4f;
  // status/control field positions and write mask
  localparam int SCR_PERMIT = 7;
  localparam int SCR_BP_EN = 5;
  localparam int SCR_BP_FORCE = 4;
  localparam logic [7:0] SCR_WR_MASK = 8'hb0;
  localparam logic [7:0] SCR_RESET = 8'h00;
  localparam logic [15:0] BP_RESET = 16'h0000;
  // field lengths in bits
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam int ADDR_W = 14;
  // timing in debug clock cycles
  localparam int DELAY_MIN_TICKS = 16;
  localparam int DELAY_MAX_TICKS = 511;
  localparam int IDLE_W = 10;
  localparam logic [IDLE_W-1:0] IDLE_TICKS = 10'h200;
  localparam logic [7:0] SYNC_TICKS = 8'h80;
  typedef enum logic [2:0] {S_CMD, S_ADDR, S_WD8, S_WD16, S_MRD, S_TX, S_IGNORE} st_e;
endpackage

// ---- logic/debug_serial_command_decoder.sv ----
// command layer of the single-wire background debug controller
// Summary of operation
// - commands start 8-bit code, MSB first
// - 512 idle ticks after fall soft-reset
// - only low 14 address bits used
// - E4 returns status/control byte
// - C4 writes status/control byte
// - sync request yields timed reference pulse
// - 18 requests whole microcontroller reset
// - 90 halts only when permit bit set
// - E0 address, delay, returns byte
// - E1 returns status then data byte
// - C0 address, data, then write
// - C1 writes byte then returns status
// - E2/C2 read/write breakpoint match register
// - 08 resumes user program, background only
// - 10 steps one instruction, background only
// - 80 streams bytes until soft-reset
// - 88 stores bytes until soft-reset
// - 6B/4B access flags and program counter
// - 6F returns zero-padded shadow counter
// - 4F loads shadow counter, ignores top bits
// - permit clear refuses background entry
`timescale 1ns/1ps
module debug_serial_command_decoder import dbg_cmd_pkg::*; #(
  parameter int DBG_DIV = 1
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic DEBUG_WIRE_PIN,
  input wire logic RX_BIT_STB,
  input wire logic RX_BIT,
  input wire logic TX_BIT_REQ,
  input wire logic SYNC_REQ,
  input wire logic BG_ACTIVE,
  input wire logic CPU_WAIT_STOP,
  input wire logic ACCESS_FAIL,
  input wire logic [1:0] CPU_FLAGS,
  input wire logic [13:0] CPU_PC,
  input wire logic [13:0] SPC_IN,
  input wire logic [7:0] MEM_RDATA,
  output logic TX_BIT,
  output logic TX_ACTIVE,
  output logic [13:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  output logic MEM_RE,
  output logic MEM_WE,
  output logic CPU_HALT_REQ,
  output logic CPU_GO,
  output logic CPU_STEP,
  output logic MCU_RESET_REQ,
  output logic CPU_REGS_WE,
  output logic [15:0] CPU_REGS_WDATA,
  output logic SPC_WE,
  output logic [13:0] SPC_WDATA,
  output logic DEBUG_PERMIT,
  output logic BP_ENABLE,
  output logic BP_FORCE,
  output logic [15:0] BP_MATCH,
  output logic SYNC_PULSE
);
  typedef struct packed {
    st_e st;
    logic [7:0] cmd;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] mem_addr;
    logic [15:0] wd;
    logic [15:0] tx;
    logic [4:0] txn;
    logic tx_on;
    logic mem_re;
    logic mem_we;
    logic halt;
    logic go;
    logic step;
    logic rst_req;
    logic regs_we;
    logic spc_we;
    logic [7:0] scr;
    logic [15:0] bp;
    logic sync_on;
    logic [7:0] sync_cnt;
  } state_s;
  state_s q;
  state_s d;
  logic tick;
  logic soft_rst;
  logic fin;
  logic [15:0] w;
  logic [4:0] need;
  logic [7:0] stat;
  logic bg_only;

  tick_divider #(.DIV(DBG_DIV)) u_div (
    .clk(CLK),
    .resetn(RESETN),
    .tick(tick)
  );

  pin_idle_monitor u_idle (
    .clk(CLK),
    .resetn(RESETN),
    .tick(tick),
    .pin(DEBUG_WIRE_PIN),
    .soft_rst(soft_rst)
  );

  always_comb begin
    d = q;
    d.mem_re = 1'b0;
    d.mem_we = 1'b0;
    d.halt = 1'b0;
    d.go = 1'b0;
    d.step = 1'b0;
    d.rst_req = 1'b0;
    d.regs_we = 1'b0;
    d.spc_we = 1'b0;
    stat = {q.scr[7], BG_ACTIVE, q.scr[5:4], 1'b0, CPU_WAIT_STOP, ACCESS_FAIL, 1'b0};
    w = {q.sh[14:0], RX_BIT};
    need = (q.st == S_ADDR || q.st == S_WD16) ? WORD_BITS : BYTE_BITS;
    fin = 1'b0;
    if (RX_BIT_STB && (q.st == S_CMD || q.st == S_ADDR || q.st == S_WD8 || q.st == S_WD16)) begin
      d.sh = w;
      d.cnt = q.cnt + 5'h01;
      if (q.cnt == need - 5'h01) begin
        fin = 1'b1;
        d.cnt = 5'h00;
      end
    end
    bg_only = 1'b0;
    case (w[7:0])
      CMD_GO, CMD_STEP, CMD_BLK_RD, CMD_BLK_WR, CMD_FPC_RD, CMD_FPC_WR, CMD_SPC_RD,
      CMD_SPC_WR: bg_only = 1'b1;
      default: bg_only = 1'b0;
    endcase
    case (q.st)
      S_CMD: begin
        if (fin) begin
          d.cmd = w[7:0];
          if (bg_only && !BG_ACTIVE) begin
            d.st = (w[7:0] == CMD_GO || w[7:0] == CMD_STEP) ? S_CMD : S_IGNORE;
          end else begin
            case (w[7:0])
              CMD_RD_STAT: begin
                d.tx = {stat, 8'h00};
                d.txn = BYTE_BITS;
                d.tx_on = 1'b1;
                d.st = S_TX;
              end
              CMD_WR_CTRL: d.st = S_WD8;
              CMD_TGT_RST: d.rst_req = 1'b1;
              CMD_HALT: d.halt = q.scr[SCR_PERMIT];
              CMD_RD_BYTE, CMD_RD_BYTE_ST, CMD_WR_BYTE, CMD_WR_BYTE_ST, CMD_BLK_RD,
              CMD_BLK_WR: d.st = S_ADDR;
              CMD_BP_RD: begin
                d.tx = q.bp;
                d.txn = WORD_BITS;
                d.tx_on = 1'b1;
                d.st = S_TX;
              end
              CMD_BP_WR, CMD_FPC_WR, CMD_SPC_WR: d.st = S_WD16;
              CMD_GO: d.go = 1'b1;
              CMD_STEP: d.step = 1'b1;
              CMD_FPC_RD: begin
                d.tx = {CPU_FLAGS, CPU_PC};
                d.txn = WORD_BITS;
                d.tx_on = 1'b1;
                d.st = S_TX;
              end
              CMD_SPC_RD: begin
                d.tx = {2'b00, SPC_IN};
                d.txn = WORD_BITS;
                d.tx_on = 1'b1;
                d.st = S_TX;
              end
              // unsupported codes are skipped whole up to the next soft-reset
              default: d.st = S_IGNORE;
            endcase
          end
        end
      end
      S_ADDR: begin
        if (fin) begin
          d.addr = w[ADDR_W-1:0];
          if (q.cmd == CMD_RD_BYTE || q.cmd == CMD_RD_BYTE_ST || q.cmd == CMD_BLK_RD) begin
            d.mem_addr = w[ADDR_W-1:0];
            d.mem_re = 1'b1;
            d.st = S_MRD;
          end else begin
            d.st = S_WD8;
          end
        end
      end
      // read data is sampled in the cycle that MEM_RE is high
      S_MRD: begin
        if (q.cmd == CMD_RD_BYTE_ST) begin
          d.tx = {stat, MEM_RDATA};
          d.txn = WORD_BITS;
        end else begin
          d.tx = {MEM_RDATA, 8'h00};
          d.txn = BYTE_BITS;
        end
        d.tx_on = 1'b1;
        d.st = S_TX;
      end
      S_WD8: begin
        if (fin) begin
          if (q.cmd == CMD_WR_CTRL) begin
            d.scr = w[7:0] & SCR_WR_MASK;
            d.st = S_CMD;
          end else begin
            d.mem_we = 1'b1;
            d.mem_addr = q.addr;
            d.wd = {8'h00, w[7:0]};
            d.st = S_CMD;
            if (q.cmd == CMD_WR_BYTE_ST) begin
              d.tx = {stat, 8'h00};
              d.txn = BYTE_BITS;
              d.tx_on = 1'b1;
              d.st = S_TX;
            end else if (q.cmd == CMD_BLK_WR) begin
              d.addr = q.addr + 14'h0001;
              d.st = S_WD8;
            end
          end
        end
      end
      S_WD16: begin
        if (fin) begin
          d.wd = w;
          d.st = S_CMD;
          case (q.cmd)
            CMD_BP_WR: d.bp = w;
            CMD_FPC_WR: d.regs_we = 1'b1;
            CMD_SPC_WR: d.spc_we = 1'b1;
            default: d.st = S_CMD;
          endcase
        end
      end
      S_TX: begin
        if (TX_BIT_REQ) begin
          d.tx = {q.tx[14:0], 1'b0};
          d.txn = q.txn - 5'h01;
          if (q.txn == 5'h01) begin
            d.tx_on = 1'b0;
            d.st = S_CMD;
            if (q.cmd == CMD_BLK_RD) begin
              d.addr = q.addr + 14'h0001;
              d.mem_addr = q.addr + 14'h0001;
              d.mem_re = 1'b1;
              d.st = S_MRD;
            end
          end
        end
      end
      S_IGNORE: d.st = S_IGNORE;
      default: d.st = S_CMD;
    endcase
    if (SYNC_REQ) begin
      d.sync_on = 1'b1;
      d.sync_cnt = SYNC_TICKS;
    end else if (q.sync_on && tick) begin
      d.sync_cnt = q.sync_cnt - 8'h01;
      if (q.sync_cnt == 8'h01) begin
        d.sync_on = 1'b0;
      end
    end
    if (soft_rst) begin
      d.st = S_CMD;
      d.cnt = 5'h00;
      d.txn = 5'h00;
      d.tx_on = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      q <= '{st: S_CMD, scr: SCR_RESET, bp: BP_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

  assign TX_BIT = q.tx[15];
  assign TX_ACTIVE = q.tx_on;
  assign MEM_ADDR = q.mem_addr;
  assign MEM_WDATA = q.wd[7:0];
  assign MEM_RE = q.mem_re;
  assign MEM_WE = q.mem_we;
  assign CPU_HALT_REQ = q.halt;
  assign CPU_GO = q.go;
  assign CPU_STEP = q.step;
  assign MCU_RESET_REQ = q.rst_req;
  assign CPU_REGS_WE = q.regs_we;
  assign CPU_REGS_WDATA = q.wd;
  assign SPC_WE = q.spc_we;
  assign SPC_WDATA = q.wd[13:0];
  assign DEBUG_PERMIT = q.scr[SCR_PERMIT];
  assign BP_ENABLE = q.scr[SCR_BP_EN];
  assign BP_FORCE = q.scr[SCR_BP_FORCE];
  assign BP_MATCH = q.bp;
  assign SYNC_PULSE = q.sync_on;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence cmd_seen(logic [7:0] c);
    q.st == S_CMD && fin && w[7:0] == c;
  endsequence
  sequence addr_seen(logic [7:0] c);
    q.st == S_ADDR && fin && q.cmd == c;
  endsequence

  status_read_a: assert property (cmd_seen(CMD_RD_STAT) |=> TX_ACTIVE && q.txn == 5'h08)
    else $error("status read did not start an 8-bit reply");
  ctrl_write_a: assert property (q.st == S_WD8 && fin && q.cmd == CMD_WR_CTRL
    |=> DEBUG_PERMIT == $past(w[7]) && BP_ENABLE == $past(w[5]))
    else $error("control write not stored");
  reset_req_a: assert property (cmd_seen(CMD_TGT_RST) |=> MCU_RESET_REQ ##1 !MCU_RESET_REQ)
    else $error("target reset request not a single pulse");
  halt_gate_a: assert property (cmd_seen(CMD_HALT) |=> CPU_HALT_REQ == $past(q.scr[7]))
    else $error("halt not gated by permit bit");
  go_gate_a: assert property (CPU_GO || CPU_STEP |-> $past(BG_ACTIVE))
    else $error("go or step issued while running");
  ignore_a: assert property ((cmd_seen(CMD_BLK_WR) ##0 !BG_ACTIVE) |=> q.st == S_IGNORE
    ##1 !MEM_WE)
    else $error("restricted command not discarded");
  soft_reset_a: assert property (soft_rst |=> q.st == S_CMD && !TX_ACTIVE)
    else $error("soft-reset did not return to command wait");
  mem_read_a: assert property (addr_seen(CMD_RD_BYTE) |=> MEM_RE
    ##1 (TX_ACTIVE && q.tx[15:8] == $past(MEM_RDATA) && q.txn == 5'h08))
    else $error("byte read reply wrong");
  blk_write_a: assert property (q.st == S_WD8 && fin && q.cmd == CMD_BLK_WR
    |=> MEM_WE && MEM_ADDR == $past(q.addr) && q.addr == $past(q.addr) + 14'h0001)
    else $error("block write address did not advance");
  spc_write_a: assert property (q.st == S_WD16 && fin && q.cmd == CMD_SPC_WR
    |=> SPC_WE && SPC_WDATA == $past(w[13:0]))
    else $error("shadow counter write wrong");
  sync_pulse_a: assert property (SYNC_REQ |=> SYNC_PULSE)
    else $error("sync pulse not started");
endmodule // debug_serial_command_decoder

// ---- logic/pin_idle_monitor.sv ----
// debug pin synchroniser and long-idle soft-reset detector
`timescale 1ns/1ps
module pin_idle_monitor import dbg_cmd_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic pin,
  output logic soft_rst
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [IDLE_W-1:0] cnt;
    logic idle;
    logic pulse;
  } mon_s;
  mon_s q;
  mon_s d;

  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pulse = 1'b0;
    if (q.s3 && !q.s2) begin
      d.cnt = '0;
      d.idle = 1'b0;
    end else if (tick && !q.idle) begin
      if (q.cnt == IDLE_TICKS - 10'h001) begin
        d.idle = 1'b1;
        d.pulse = 1'b1;
      end else begin
        d.cnt = q.cnt + 10'h001;
      end
    end
  end

  // idle line at reset counts as already soft-reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: '0, idle: 1'b1, pulse: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign soft_rst = q.pulse;
endmodule // pin_idle_monitor

// ---- logic/tick_divider.sv ----
// debug clock enable: one-cycle pulse every DIV clock cycles
`timescale 1ns/1ps
module tick_divider import dbg_cmd_pkg::*; #(
  parameter int DIV = 1
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } div_s;
  div_s q;
  div_s d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt >= 16'(DIV - 1)) begin
      d.cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule // tick_divider

// ---- verification/dbg_host_model.sv ----
// debug host model acting on the bit layer of the command decoder
`timescale 1ns/1ps
module dbg_host_model (
  input wire logic clk,
  input wire logic tx_bit,
  input wire logic tx_active,
  output logic pin,
  output logic rx_stb,
  output logic rx_bit,
  output logic tx_req
);
  initial begin
    pin = 1'b1;
    rx_stb = 1'b0;
    rx_bit = 1'b0;
    tx_req = 1'b0;
  end
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk);
      pin = 1'b0;
      rx_stb = 1'b1;
      rx_bit = v[i];
      @(negedge clk);
      pin = 1'b1;
      rx_stb = 1'b0;
      // no stale bit left between strobes
      rx_bit = ~v[i];
    end
  endtask
  task automatic recv(output logic [15:0] v, input int n);
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      for (int w = 0; w < 600 && tx_active !== 1'b1; w++)
        @(negedge clk);
      v = {v[14:0], tx_bit};
      pin = 1'b0;
      tx_req = 1'b1;
      @(negedge clk);
      pin = 1'b1;
      tx_req = 1'b0;
    end
  endtask
  task automatic dly(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic idle();
    repeat (530) @(negedge clk);
  endtask
endmodule // dbg_host_model

// ---- verification/tb_debug_serial_command_decoder.sv ----
// self-checking bench of the debug command decoder
`timescale 1ns/1ps
module tb_debug_serial_command_decoder;
  import dbg_cmd_pkg::*;
  logic clk, resetn, pin, stb, rxb, treq, sreq, bg, ws, af;
  logic txb, txa, re, we, halt, go, step, mrst, rwe, swe, permit, bpen, bpf, spulse;
  logic [1:0] fl;
  logic [13:0] pc, spc_in, maddr, spcw, wa, swd, ra;
  logic [7:0] mrd, mwd, wd;
  logic [15:0] rwdata, bpm, rwd, v;
  int np[6] = '{default: 0};
  int nw = 0;
  int nr = 0;
  int cyc = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  // memory returns a fixed pattern of its address
  assign mrd = maddr[7:0] ^ 8'h3c;
  debug_serial_command_decoder #(.DBG_DIV(1)) dut (
    .CLK(clk), .RESETN(resetn), .DEBUG_WIRE_PIN(pin), .RX_BIT_STB(stb),
    .RX_BIT(rxb), .TX_BIT_REQ(treq), .SYNC_REQ(sreq), .BG_ACTIVE(bg),
    .CPU_WAIT_STOP(ws), .ACCESS_FAIL(af), .CPU_FLAGS(fl), .CPU_PC(pc),
    .SPC_IN(spc_in), .MEM_RDATA(mrd), .TX_BIT(txb), .TX_ACTIVE(txa),
    .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_RE(re), .MEM_WE(we),
    .CPU_HALT_REQ(halt), .CPU_GO(go), .CPU_STEP(step), .MCU_RESET_REQ(mrst),
    .CPU_REGS_WE(rwe), .CPU_REGS_WDATA(rwdata), .SPC_WE(swe), .SPC_WDATA(spcw),
    .DEBUG_PERMIT(permit), .BP_ENABLE(bpen), .BP_FORCE(bpf), .BP_MATCH(bpm),
    .SYNC_PULSE(spulse)
  );
  dbg_host_model host (
    .clk(clk), .tx_bit(txb), .tx_active(txa), .pin(pin), .rx_stb(stb),
    .rx_bit(rxb), .tx_req(treq)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // pulse counts: long pulses count more than once
  always @(posedge clk) begin
    cyc++;
    np[0] += halt;
    np[1] += go;
    np[2] += step;
    np[3] += mrst;
    np[4] += rwe;
    np[5] += swe;
    if (rwe) rwd = rwdata;
    if (swe) swd = spcw;
    if (re) begin
      ra = maddr;
      nr++;
    end
    if (we) begin
      wa = maddr;
      wd = mwd;
      nw++;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic ca(input logic [7:0] c, input logic [15:0] a);
    host.send({8'h00, c}, 8);
    host.send(a, 16);
  endtask
  task automatic rd(input logic [7:0] c, input int n, input logic [31:0] e);
    host.send({8'h00, c}, 8);
    host.dly(16);
    host.recv(v, n);
    chk(v, e);
  endtask
  task automatic t_status();
    host.send(16'h00c4, 8);
    host.send(16'h00ff, 8);
    host.dly(2);
    chk({permit, bpen, bpf}, 3'h7);
    rd(8'he4, 8, 32'hb4);
    host.send(16'h00c4, 8);
    host.send(16'h0040, 8);
    {ws, af} = 2'h1;
    rd(8'he4, 8, 32'h02);
    $display("done status");
  endtask
  task automatic t_halt();
    int h;
    h = np[0];
    host.send(16'h0090, 8);
    host.dly(16);
    chk(np[0], h);
    host.send(16'h00c4, 8);
    host.send(16'h0080, 8);
    host.send(16'h0090, 8);
    host.dly(16);
    chk(np[0], h + 1);
    $display("done halt");
  endtask
  task automatic t_mem();
    int n;
    ca(8'hc0, 16'hc012);
    host.send(16'h00a5, 8);
    host.dly(16);
    chk(wa, 14'h0012);
    chk(wd, 8'ha5);
    n = nr;
    ca(8'he0, 16'h4077);
    // longest slot is counted fall to fall: send and recv each add one cycle
    host.dly(DELAY_MAX_TICKS - 2);
    host.recv(v, 8);
    chk(v, 8'h4b);
    chk(nr, n + 1);
    chk(ra, 14'h0077);
    ca(8'he1, 16'h0123);
    host.dly(16);
    host.recv(v, 16);
    chk(v, 16'h821f);
    ca(8'hc1, 16'h3fff);
    host.send(16'h005a, 8);
    host.dly(16);
    host.recv(v, 8);
    chk(v, 8'h82);
    chk({wa, wd}, {14'h3fff, 8'h5a});
    $display("done memory");
  endtask
  task automatic t_misc();
    int h;
    h = np[3];
    ca(8'hc2, 16'hc123);
    host.dly(2);
    chk(bpm, 16'hc123);
    rd(8'he2, 16, 32'hc123);
    host.send(16'h0018, 8);
    host.dly(2);
    chk(np[3], h + 1);
    h = 0;
    sreq = 1'b1;
    @(negedge clk);
    sreq = 1'b0;
    // pulse is already high at this edge
    repeat (300) begin
      h += spulse;
      @(negedge clk);
    end
    chk(h, 128);
    $display("done misc");
  endtask
  task automatic t_running();
    int g, s, p, n;
    {g, s, p, n} = {np[1], np[2], np[5], nw};
    host.send(16'h0008, 8);
    host.dly(16);
    host.send(16'h0010, 8);
    host.dly(16);
    chk(np[1], g);
    chk(np[2], s);
    ca(8'h4f, 16'hffff);
    host.dly(16);
    host.idle();
    chk(np[5], p);
    ca(8'h88, 16'h0010);
    host.send(16'h0077, 8);
    host.dly(16);
    host.idle();
    chk(nw, n);
    rd(8'he4, 8, 32'h82);
    $display("done running");
  endtask
  task automatic t_bg();
    int g, s;
    {g, s} = {np[1], np[2]};
    bg = 1'b1;
    rd(8'h6b, 16, 32'h9234);
    host.send(16'h004b, 8);
    host.send(16'h7fed, 16);
    host.dly(16);
    chk(rwd, 16'h7fed);
    rd(8'h6f, 16, 32'h2abc);
    {fl, pc, spc_in} = {2'h1, 14'h3fc0, 14'h0155};
    rd(8'h6b, 16, 32'h7fc0);
    rd(8'h6f, 16, 32'h0155);
    host.send(16'h004f, 8);
    host.send(16'hffff, 16);
    host.dly(16);
    chk(swd, 14'h3fff);
    host.send(16'h0010, 8);
    host.dly(16);
    chk(np[2], s + 1);
    host.send(16'h0008, 8);
    host.dly(16);
    chk(np[1], g + 1);
    $display("done background");
  endtask
  task automatic t_block();
    ca(8'h80, 16'h00fe);
    for (int i = 0; i < 3; i++) begin
      host.dly(16);
      host.recv(v, 8);
      chk(v, 8'(8'hfe + i) ^ 8'h3c);
    end
    host.idle();
    ca(8'h88, 16'hc0fe);
    for (int i = 0; i < 3; i++) begin
      host.send(16'(16'h0010 + i), 8);
      host.dly(16);
      chk({wa, wd}, {14'(14'h00fe + i), 8'(8'h10 + i)});
    end
    host.idle();
    rd(8'he4, 8, 32'hc2);
    $display("done block");
  endtask
  initial begin
    {resetn, sreq, bg, ws, af} = 5'h02;
    fl = 2'h2;
    pc = 14'h1234;
    spc_in = 14'h2abc;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    t_status();
    t_halt();
    t_mem();
    t_misc();
    t_running();
    t_bg();
    t_block();
    conclude();
  end
endmodule // tb_debug_serial_command_decoder
